//--- abp_pkg.sv
//
// Function
// - Audio words are 18 bits on both buses
// - Local bus reached only via shared latches
// - Memory read, write strobe low, latch word
// - Plain write, strobe low, also latches word
// - Strobe returns high after latch load
// - Local write strobe leaves shared control alone
// - Fetch: assert instruction, address, read strobe
// - Addressed card drives latch; reader gates in
// - Channel write: latched word clocked by strobe
// - Input read: buffer drives, reader gates in
// - Exchange register works only in test
// - Host transfers reuse write/read sequences
// - Relatch control bits; decode local controls
// - Five address bits, 32 shared addresses
// - Write select and enable decode four operations
// - Read/write strobe bits select the I/O direction
//
package abp_pkg;

  // ----------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------
  localparam int unsigned ABP_WORD_W      = 18;
  localparam int unsigned ABP_ADDR_W      = 5;
  localparam int unsigned ABP_FIFO_DEPTH  = 32;
  localparam int unsigned ABP_CLK_NS      = 10;

  // ----------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------
  localparam logic [7:0] ABP_OFS_CTRL     = 8'h00;
  localparam logic [7:0] ABP_OFS_CARD_ID  = 8'h04;
  localparam logic [7:0] ABP_OFS_MICRO    = 8'h08;
  localparam logic [7:0] ABP_OFS_LOCAL    = 8'h0C;
  localparam logic [7:0] ABP_OFS_XCHG     = 8'h10;
  localparam logic [7:0] ABP_OFS_STATUS   = 8'h14;
  localparam logic [7:0] ABP_OFS_LATCH    = 8'h18;
  localparam logic [4:0] ABP_CARD_ID_RST  = 5'h00;
  localparam logic [9:0] ABP_MICRO_RST    = 10'h3E0;

  // ----------------------------------------------------------
  // Microword field positions
  // ----------------------------------------------------------
  localparam int unsigned ABP_MW_WR_N     = 5;
  localparam int unsigned ABP_MW_RD_N     = 6;
  localparam int unsigned ABP_MW_IO_N     = 7;
  localparam int unsigned ABP_MW_MEMEN_N  = 8;
  localparam int unsigned ABP_MW_WSEL     = 9;

  // ----------------------------------------------------------
  // Shared addresses of the exchange register
  // ----------------------------------------------------------
  localparam logic [4:0] ABP_XCHG_WR_ADDR = 5'h1E;
  localparam logic [4:0] ABP_XCHG_RD_ADDR = 5'h1F;

  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    ABP_OP_MEM_RD = 2'b00,
    ABP_OP_IO_RD  = 2'b01,
    ABP_OP_MEM_WR = 2'b10,
    ABP_OP_IO_WR  = 2'b11
  } abp_op_e;

  typedef enum logic [4:0] {
    ABP_ST_IDLE    = 5'b00001,
    ABP_ST_RELATCH = 5'b00010,
    ABP_ST_SETUP   = 5'b00100,
    ABP_ST_DRIVE   = 5'b01000,
    ABP_ST_RELEASE = 5'b10000
  } abp_state_e;

  function automatic abp_op_e abp_mem_op(input logic wsel, input logic memen_n);
    abp_mem_op = abp_op_e'({wsel, memen_n});
  endfunction : abp_mem_op

endpackage : abp_pkg

//--- abp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module abp_fifo
  import abp_pkg::*;
#(
  parameter int unsigned WIDTH = ABP_WORD_W,
  parameter int unsigned DEPTH = ABP_FIFO_DEPTH
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic      [WIDTH-1:0]           out_data_o,
  output logic      [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0]    cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready_o  = (cnt_reg != CW'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign count_o     = cnt_reg;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;

  always_comb begin
    wr_ptr_next = push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
    rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
    cnt_next    = CW'(cnt_reg + CW'(push) - CW'(pop));
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule : abp_fifo
`default_nettype wire

//--- abp_step_decode.sv
`timescale 1ns/100ps
`default_nettype none
module abp_step_decode
  import abp_pkg::*;
(
  input  wire logic       io_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       memen_n_i,
  input  wire logic       wsel_i,
  input  wire logic [4:0] addr_i,
  input  wire logic       test_en_i,
  output logic            latch_load_o,
  output logic            bus_read_o,
  output logic            bus_write_o,
  output logic            xchg_wr_sel_o,
  output logic            xchg_rd_sel_o
);
  abp_op_e op;

  always_comb begin
    op            = abp_mem_op(wsel_i, memen_n_i);
    latch_load_o  = io_n_i & ~wr_n_i & ((op == ABP_OP_MEM_RD) | (op == ABP_OP_IO_WR));
    bus_read_o    = ~io_n_i & ~rd_n_i;
    bus_write_o   = ~io_n_i & ~wr_n_i & rd_n_i;
    xchg_wr_sel_o = bus_write_o & (addr_i == ABP_XCHG_WR_ADDR) & test_en_i;
    xchg_rd_sel_o = bus_read_o & (addr_i == ABP_XCHG_RD_ADDR) & test_en_i;
  end
endmodule : abp_step_decode
`default_nettype wire

//--- abp_audio_port.sv
`timescale 1ns/100ps
`default_nettype none
module abp_audio_port
  import abp_pkg::*;
#(
  parameter int unsigned WORD_W     = ABP_WORD_W,
  parameter int unsigned FIFO_DEPTH = ABP_FIFO_DEPTH
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  output logic      [31:0]           hrdata_o,
  input  wire logic                  shared_io_n_i,
  input  wire logic                  shared_rd_n_i,
  input  wire logic                  shared_wr_n_i,
  input  wire logic [ABP_ADDR_W-1:0] shared_addr_i,
  input  wire logic [WORD_W-1:0]     shared_data_i,
  output logic                       shared_ctl_oe_o,
  output logic                       shared_io_n_o,
  output logic                       shared_rd_n_o,
  output logic                       shared_wr_n_o,
  output logic      [ABP_ADDR_W-1:0] shared_addr_o,
  output logic      [WORD_W-1:0]     shared_data_o,
  output logic                       shared_data_oe_o
);
  localparam int unsigned CW = $clog2(FIFO_DEPTH+1);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic              pend_reg, pend_next, pwr_reg, pwr_next;
  logic [7:0]        paddr_reg, paddr_next;
  logic              hready_reg, hready_next;
  logic [31:0]       hrdata_reg, hrdata_next;
  logic              test_reg, test_next;
  logic [4:0]        id_reg, id_next;
  abp_state_e        st_reg, st_next;
  logic [9:0]        mw_reg, mw_next, io_reg, io_next;
  logic [WORD_W-1:0] latch_reg, latch_next, rx_reg, rx_next, xchg_reg, xchg_next;
  logic              ctl_oe_reg, ctl_oe_next, io_n_reg, io_n_next;
  logic              rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
  logic [4:0]        addr_reg, addr_next;
  logic [WORD_W-1:0] dout_reg, dout_next;
  logic              doe_reg, doe_next;

  logic              fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;
  logic [CW-1:0]     fifo_count;
  logic              accept, done, mw_start, xchg_bus_wr;
  logic              dec_load, dec_rd, dec_wr, dec_xwr, dec_xrd;
  logic              other_rd, other_wr;

  // ----------------------------------------------------------
  // Local word buffer and control decode
  // ----------------------------------------------------------
  abp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (hwdata_i[WORD_W-1:0]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data),
    .count_o     (fifo_count)
  );

  abp_step_decode u_dec (
    .io_n_i        (io_reg[ABP_MW_IO_N]),
    .rd_n_i        (io_reg[ABP_MW_RD_N]),
    .wr_n_i        (io_reg[ABP_MW_WR_N]),
    .memen_n_i     (io_reg[ABP_MW_MEMEN_N]),
    .wsel_i        (io_reg[ABP_MW_WSEL]),
    .addr_i        (io_reg[4:0]),
    .test_en_i     (test_reg),
    .latch_load_o  (dec_load),
    .bus_read_o    (dec_rd),
    .bus_write_o   (dec_wr),
    .xchg_wr_sel_o (dec_xwr),
    .xchg_rd_sel_o (dec_xrd)
  );

  // ----------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------
  assign accept        = hsel_i & htrans_i[1] & hready_i;
  assign fifo_in_valid = pend_reg & pwr_reg & (paddr_reg == ABP_OFS_LOCAL);
  assign mw_start      = pend_reg & pwr_reg & (paddr_reg == ABP_OFS_MICRO) & (st_reg == ABP_ST_IDLE);
  assign xchg_bus_wr   = pend_reg & pwr_reg & (paddr_reg == ABP_OFS_XCHG) & test_reg;

  always_comb begin
    pend_next   = pend_reg;
    pwr_next    = pwr_reg;
    paddr_next  = paddr_reg;
    hready_next = hready_reg;
    hrdata_next = hrdata_reg;
    test_next   = test_reg;
    id_next     = id_reg;
    done        = 1'b1;
    if (pwr_reg && paddr_reg == ABP_OFS_LOCAL) begin
      done = fifo_in_ready;
    end else if (pwr_reg && paddr_reg == ABP_OFS_MICRO) begin
      done = (st_reg == ABP_ST_IDLE);
    end
    if (pend_reg && done) begin
      pend_next   = 1'b0;
      hready_next = 1'b1;
      hrdata_next = '0;
      if (pwr_reg) begin
        if (paddr_reg == ABP_OFS_CTRL) begin
          test_next = hwdata_i[0];
        end
        if (paddr_reg == ABP_OFS_CARD_ID) begin
          id_next = hwdata_i[4:0];
        end
      end else begin
        case (paddr_reg)
          ABP_OFS_CTRL:    hrdata_next = 32'(test_reg);
          ABP_OFS_CARD_ID: hrdata_next = 32'(id_reg);
          ABP_OFS_MICRO:   hrdata_next = 32'(mw_reg);
          ABP_OFS_LOCAL:   hrdata_next = 32'(rx_reg);
          ABP_OFS_XCHG:    hrdata_next = 32'(xchg_reg);
          ABP_OFS_STATUS:  hrdata_next = 32'({fifo_count, st_reg != ABP_ST_IDLE});
          ABP_OFS_LATCH:   hrdata_next = 32'(latch_reg);
          default:         hrdata_next = '0;
        endcase
      end
    end
    if (accept) begin
      pend_next   = 1'b1;
      pwr_next    = hwrite_i;
      paddr_next  = haddr_i[7:0];
      hready_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pend_reg   <= 1'b0;
      pwr_reg    <= 1'b0;
      paddr_reg  <= '0;
      hready_reg <= 1'b1;
      hrdata_reg <= '0;
      test_reg   <= 1'b0;
      id_reg     <= ABP_CARD_ID_RST;
    end else begin
      pend_reg   <= pend_next;
      pwr_reg    <= pwr_next;
      paddr_reg  <= paddr_next;
      hready_reg <= hready_next;
      hrdata_reg <= hrdata_next;
      test_reg   <= test_next;
      id_reg     <= id_next;
    end
  end

  assign hreadyout_o = hready_reg;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_reg;

  // ----------------------------------------------------------
  // Microstep sequencer and shared bus
  // ----------------------------------------------------------
  assign fifo_out_ready = (st_reg == ABP_ST_SETUP) & dec_load;
  assign other_rd = ~shared_io_n_i & ~shared_rd_n_i;
  assign other_wr = ~shared_io_n_i & ~shared_wr_n_i;

  always_comb begin
    st_next     = st_reg;
    mw_next     = mw_reg;
    io_next     = io_reg;
    latch_next  = latch_reg;
    rx_next     = rx_reg;
    xchg_next   = xchg_reg;
    ctl_oe_next = ctl_oe_reg;
    io_n_next   = io_n_reg;
    rd_n_next   = rd_n_reg;
    wr_n_next   = wr_n_reg;
    addr_next   = addr_reg;
    dout_next   = dout_reg;
    doe_next    = 1'b0;
    if (xchg_bus_wr) begin
      xchg_next = hwdata_i[WORD_W-1:0];
    end
    unique case (st_reg)
      ABP_ST_IDLE: begin
        ctl_oe_next = 1'b0;
        if (mw_start) begin
          mw_next = hwdata_i[9:0];
          st_next = ABP_ST_RELATCH;
        end
        if (other_rd && shared_addr_i == id_reg) begin
          doe_next  = 1'b1;
          dout_next = latch_reg;
        end else if (other_rd && shared_addr_i == ABP_XCHG_RD_ADDR && test_reg) begin
          doe_next  = 1'b1;
          dout_next = xchg_reg;
        end else if (other_wr && shared_addr_i == ABP_XCHG_WR_ADDR && test_reg) begin
          xchg_next = shared_data_i;
        end
      end
      ABP_ST_RELATCH: begin
        io_next = mw_reg;
        st_next = ABP_ST_SETUP;
      end
      ABP_ST_SETUP: begin
        if (!dec_load || fifo_out_valid) begin
          if (dec_load) begin
            latch_next = fifo_out_data;
          end
          ctl_oe_next = ~io_reg[ABP_MW_IO_N];
          io_n_next   = io_reg[ABP_MW_IO_N];
          rd_n_next   = io_reg[ABP_MW_RD_N] | io_reg[ABP_MW_IO_N];
          wr_n_next   = io_reg[ABP_MW_WR_N] | io_reg[ABP_MW_IO_N];
          addr_next   = io_reg[4:0];
          doe_next    = dec_wr & ~dec_xwr;
          dout_next   = dec_load ? fifo_out_data : latch_reg;
          st_next     = ABP_ST_DRIVE;
        end
      end
      ABP_ST_DRIVE: begin
        if (dec_rd) begin
          rx_next = dec_xrd ? xchg_reg : shared_data_i;
        end
        if (dec_xwr) begin
          xchg_next = latch_reg;
        end
        rd_n_next = 1'b1;
        wr_n_next = 1'b1;
        st_next   = ABP_ST_RELEASE;
      end
      ABP_ST_RELEASE: begin
        ctl_oe_next = 1'b0;
        io_n_next   = 1'b1;
        st_next     = ABP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_reg     <= ABP_ST_IDLE;
      mw_reg     <= ABP_MICRO_RST;
      io_reg     <= ABP_MICRO_RST;
      latch_reg  <= '0;
      rx_reg     <= '0;
      xchg_reg   <= '0;
      ctl_oe_reg <= 1'b0;
      io_n_reg   <= 1'b1;
      rd_n_reg   <= 1'b1;
      wr_n_reg   <= 1'b1;
      addr_reg   <= '0;
      dout_reg   <= '0;
      doe_reg    <= 1'b0;
    end else begin
      st_reg     <= st_next;
      mw_reg     <= mw_next;
      io_reg     <= io_next;
      latch_reg  <= latch_next;
      rx_reg     <= rx_next;
      xchg_reg   <= xchg_next;
      ctl_oe_reg <= ctl_oe_next;
      io_n_reg   <= io_n_next;
      rd_n_reg   <= rd_n_next;
      wr_n_reg   <= wr_n_next;
      addr_reg   <= addr_next;
      dout_reg   <= dout_next;
      doe_reg    <= doe_next;
    end
  end

  assign shared_ctl_oe_o  = ctl_oe_reg;
  assign shared_io_n_o    = io_n_reg;
  assign shared_rd_n_o    = rd_n_reg;
  assign shared_wr_n_o    = wr_n_reg;
  assign shared_addr_o    = addr_reg;
  assign shared_data_o    = dout_reg;
  assign shared_data_oe_o = doe_reg;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_latch_load: assert property ((st_reg == ABP_ST_SETUP) && dec_load && fifo_out_valid
    |=> latch_reg == $past(fifo_out_data)) else $error("Latch not loaded");
  a_strobe_back: assert property ((st_reg == ABP_ST_DRIVE) |=> shared_rd_n_o && shared_wr_n_o)
    else $error("Strobe not released");
  a_local_only: assert property ((st_reg == ABP_ST_DRIVE) && io_reg[ABP_MW_IO_N]
    |-> !shared_ctl_oe_o && !shared_data_oe_o) else $error("Local step touched shared bus");
  a_fetch_drive: assert property ((st_reg == ABP_ST_DRIVE) && dec_rd
    |-> shared_ctl_oe_o && !shared_io_n_o && !shared_rd_n_o && shared_addr_o == io_reg[4:0])
    else $error("Fetch not driven");
  a_answer_read: assert property ((st_reg == ABP_ST_IDLE) && other_rd && shared_addr_i == id_reg
    |=> shared_data_oe_o && shared_data_o == $past(latch_reg)) else $error("Addressed card silent");
  a_chan_write: assert property ((st_reg == ABP_ST_DRIVE) && dec_wr && !dec_xwr
    |-> shared_data_oe_o && !shared_wr_n_o && shared_data_o == latch_reg) else $error("Write not driven");
  a_input_read: assert property ((st_reg == ABP_ST_DRIVE) && dec_rd && !dec_xrd
    |=> rx_reg == $past(shared_data_i)) else $error("Input word not gated");
  a_xchg_test: assert property (!test_reg |=> $stable(xchg_reg))
    else $error("Exchange register moved outside test");
  a_one_source: assert property (shared_data_oe_o |-> !(shared_ctl_oe_o && !shared_rd_n_o))
    else $error("Two data sources");
  a_relatch: assert property ((st_reg == ABP_ST_IDLE) && mw_start
    |=> (st_reg == ABP_ST_RELATCH) ##1 (io_reg == $past(mw_reg))) else $error("Microword not relatched");

  c_bus_read: cover property ((st_reg == ABP_ST_DRIVE) && dec_rd && !dec_xrd);
  c_bus_write: cover property ((st_reg == ABP_ST_DRIVE) && dec_wr);
  c_local_load: cover property ((st_reg == ABP_ST_SETUP) && dec_load && fifo_out_valid);
  c_answer: cover property (shared_data_oe_o && (st_reg == ABP_ST_IDLE));
endmodule : abp_audio_port
`default_nettype wire

//--- abp_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module abp_far_model
  import abp_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ctl_oe_i,
  input  wire logic        io_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [4:0]  addr_i,
  input  wire logic [17:0] data_i,
  input  wire logic        data_oe_i,
  input  wire logic        fetch_i,
  input  wire logic [4:0]  fetch_addr_i,
  output logic             io_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic      [4:0]  addr_o,
  output logic      [17:0] data_o,
  output logic      [17:0] out_word_o,
  output logic      [4:0]  out_addr_o,
  output logic             clash_o
);
  logic        src_en;
  logic [17:0] last_data;
  logic [4:0]  last_addr;
  // ----------------------------------------
  // Bus resolution, control pulled up
  // ----------------------------------------
  always_comb begin
    io_n_o = ctl_oe_i ? io_n_i : !fetch_i;
    rd_n_o = ctl_oe_i ? rd_n_i : !fetch_i;
    wr_n_o = ctl_oe_i ? wr_n_i : 1'b1;
    addr_o = ctl_oe_i ? addr_i : (fetch_i ? fetch_addr_i : ~last_addr);
    src_en = ctl_oe_i && !io_n_i && !rd_n_i && (addr_i < 5'h16 || addr_i == 5'h1C || addr_i == 5'h1D);
    data_o = data_oe_i ? data_i : (src_en ? (18'h2_5A00 ^ {13'h0, addr_i}) : ~last_data);
  end
  // ----------------------------------------
  // Output channel registers
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      last_data  <= '0;
      last_addr  <= '0;
      clash_o    <= 1'b0;
      out_word_o <= '0;
      out_addr_o <= '0;
    end else begin
      last_data <= data_o;
      last_addr <= addr_o;
      if (data_oe_i && src_en) clash_o <= 1'b1;
      if (!io_n_o && !wr_n_o && addr_o[4:2] == 3'b110) begin
        out_word_o <= data_o;
        out_addr_o <= addr_o;
      end
    end
  end
endmodule : abp_far_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
  import abp_pkg::*;
;
  logic        sys_clk_i, rst_n_i, hsel_r, hwrite_r, fetch_r, ctl_seen;
  logic [1:0]  htrans_r;
  logic [31:0] haddr_r, hwdata_r, hrdata;
  logic        hreadyout, hresp, ctl_oe, io_n_d, rd_n_d, wr_n_d, data_oe;
  logic        io_n_b, rd_n_b, wr_n_b, clash;
  logic [4:0]  addr_d, addr_b, fetch_addr_r, out_addr;
  logic [17:0] data_d, data_b, out_word;
  int          bad_count, checks;

  abp_audio_port dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_r), .haddr_i(haddr_r), .htrans_i(htrans_r),
    .hwrite_i(hwrite_r), .hsize_i(3'b010), .hwdata_i(hwdata_r), .hready_i(hreadyout), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .hrdata_o(hrdata), .shared_io_n_i(io_n_b), .shared_rd_n_i(rd_n_b), .shared_wr_n_i(wr_n_b),
    .shared_addr_i(addr_b), .shared_data_i(data_b), .shared_ctl_oe_o(ctl_oe), .shared_io_n_o(io_n_d),
    .shared_rd_n_o(rd_n_d), .shared_wr_n_o(wr_n_d), .shared_addr_o(addr_d), .shared_data_o(data_d),
    .shared_data_oe_o(data_oe));
  abp_far_model u_far (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ctl_oe_i(ctl_oe), .io_n_i(io_n_d), .rd_n_i(rd_n_d),
    .wr_n_i(wr_n_d), .addr_i(addr_d), .data_i(data_d), .data_oe_i(data_oe), .fetch_i(fetch_r),
    .fetch_addr_i(fetch_addr_r), .io_n_o(io_n_b), .rd_n_o(rd_n_b), .wr_n_o(wr_n_b), .addr_o(addr_b),
    .data_o(data_b), .out_word_o(out_word), .out_addr_o(out_addr), .clash_o(clash));

  always @(posedge sys_clk_i) if (ctl_oe === 1'b1) ctl_seen <= 1'b1;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel_r <= 1'b1; htrans_r <= 2'b10; haddr_r <= {24'h00_0000, a}; hwrite_r <= w;
    do begin @(posedge sys_clk_i); n++; end while (hreadyout !== 1'b1 && n < 500);
    htrans_r <= 2'b00; hwdata_r <= wd;
    do begin @(posedge sys_clk_i); n++; end while (hreadyout !== 1'b1 && n < 500);
    rd = hrdata;
    if (n >= 500) bad_count++;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    check(d, exp);
  endtask : rdchk
  task automatic step(input logic [9:0] mw);
    logic [31:0] s;
    int n;
    n = 0;
    wr(ABP_OFS_MICRO, {22'h00_0000, mw});
    do begin bus(1'b0, ABP_OFS_STATUS, 32'h0000_0000, s); n++; end while (s[0] !== 1'b0 && n < 50);
    if (s[0] !== 1'b0) bad_count++;
  endtask : step
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(hresp, 0);
    check({ctl_oe, data_oe}, 0);
    rdchk(ABP_OFS_CTRL, 32'h0000_0000);
    rdchk(ABP_OFS_MICRO, 32'h0000_03E0);
    rdchk(ABP_OFS_STATUS, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk(8'h40, 32'h0000_0000);
    $display("done reset");
  endtask : t_reset
  task automatic t_latch();
    wr(ABP_OFS_LOCAL, 32'h0001_2345);
    rdchk(ABP_OFS_STATUS, 32'h0000_0002);
    ctl_seen = 1'b0;
    step(10'h0C0);
    rdchk(ABP_OFS_LATCH, 32'h0001_2345);
    wr(ABP_OFS_LOCAL, 32'h0002_ABCD);
    step(10'h2C0);
    rdchk(ABP_OFS_LATCH, 32'h0001_2345);
    rdchk(ABP_OFS_STATUS, 32'h0000_0002);
    step(10'h3C0);
    rdchk(ABP_OFS_LATCH, 32'h0002_ABCD);
    check(ctl_seen, 0);
    $display("done latch load");
  endtask : t_latch
  task automatic t_out();
    logic [31:0] w;
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 32'hFFFF_FFFF : 32'h0002_0F00 + 32'(i);
      wr(ABP_OFS_LOCAL, w);
      step(10'h0C0);
      step(10'(10'h358 + i));
      check(out_word, {14'h0000, w[17:0]});
      check(out_addr, 32'(5'h18 + i));
    end
    $display("done output channels");
  endtask : t_out
  task automatic t_in();
    logic [4:0] src [9] = '{5'h03, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1C, 5'h1D};
    foreach (src[k]) begin
      step(10'h120 | {5'h00, src[k]});
      rdchk(ABP_OFS_LOCAL, {14'h0000, 18'h2_5A00 ^ {13'h0000, src[k]}});
    end
    check(clash, 0);
    $display("done input reads");
  endtask : t_in
  task automatic t_fetch();
    wr(ABP_OFS_CARD_ID, 32'h0000_0005);
    wr(ABP_OFS_LOCAL, 32'h0001_5555);
    step(10'h0C0);
    fetch_addr_r <= 5'h05;
    fetch_r <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    check(data_oe, 1);
    check(data_b, 32'h0001_5555);
    fetch_addr_r <= 5'h06;
    repeat (2) @(posedge sys_clk_i);
    check(data_oe, 0);
    fetch_r <= 1'b0;
    $display("done card fetch");
  endtask : t_fetch
  task automatic t_xchg();
    wr(ABP_OFS_XCHG, 32'h0000_0155);
    rdchk(ABP_OFS_XCHG, 32'h0000_0000);
    wr(ABP_OFS_CTRL, 32'h0000_0001);
    wr(ABP_OFS_XCHG, 32'h0002_0304);
    rdchk(ABP_OFS_XCHG, 32'h0002_0304);
    step(10'h13F);
    rdchk(ABP_OFS_LOCAL, 32'h0002_0304);
    wr(ABP_OFS_LOCAL, 32'h0001_0F0F);
    step(10'h0C0);
    step(10'h35E);
    rdchk(ABP_OFS_XCHG, 32'h0001_0F0F);
    fetch_addr_r <= ABP_XCHG_RD_ADDR;
    fetch_r <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    check(data_oe, 1);
    check(data_b, 32'h0001_0F0F);
    fetch_r <= 1'b0;
    check(clash, 0);
    $display("done exchange register");
  endtask : t_xchg
  task automatic t_fifo();
    for (int k = 0; k < 32; k++) wr(ABP_OFS_LOCAL, 32'h0000_0100 + 32'(k));
    rdchk(ABP_OFS_STATUS, 32'h0000_0040);
    for (int k = 0; k < 32; k++) begin
      step(10'h0C0);
      rdchk(ABP_OFS_LATCH, 32'h0000_0100 + 32'(k));
    end
    rdchk(ABP_OFS_STATUS, 32'h0000_0000);
    $display("done buffer fill and drain");
  endtask : t_fifo
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // ----------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    rst_n_i = 1'b0; hsel_r = 1'b0; hwrite_r = 1'b0; htrans_r = 2'b00; haddr_r = '0; hwdata_r = '0;
    fetch_r = 1'b0; fetch_addr_r = 5'h00; ctl_seen = 1'b0; bad_count = 0; checks = 0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset();
    t_latch();
    t_out();
    t_in();
    t_fetch();
    t_xchg();
    t_fifo();
    results();
  end
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    bad_count++;
    results();
  end
endmodule : tb
`default_nettype wire
